/* File: bench/drpc_chk.sv */
// Assertion checker for the reset and playback control block.
// Assumes it is bound to drpc_top and sees its ports only.
`timescale 1ns/100ps
module drpc_chk
	import drpc_pkg::*;
#(
	parameter int unsigned BOOT_CYCLES = 20
)
(
	// Clock, reset and requests
	input wire logic               clk_in,
	input wire logic               reset_n_in,
	input wire drpc_pkg::drpc_wr_t wr_in,
	input wire logic               stream_valid_in,
	input wire logic               cancel_done_in,
	input wire logic               pos_exact_in,
	input wire logic               control_select_low_in,
	input wire logic               serial_data_in,
	// Watched outputs
	input wire logic               control_serial_out,
	input wire logic               control_serial_oe_n_out,
	input wire logic [15:0]        mode_register_out,
	input wire logic [15:0]        stream_header_lo_out,
	input wire logic [15:0]        stream_header_hi_out,
	input wire logic [31:0]        exact_position_ms_out,
	input wire logic               data_request_flag_out,
	input wire logic               core_clk_en_out,
	input wire logic               pll_enable_out,
	input wire logic               analog_drivers_on_out,
	input wire logic               crystal_out_ground_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	// Cycles with ready low since the last restart
	logic [15:0] low_cnt_reg;
	always_ff @(posedge clk_in)
		low_cnt_reg <= (!reset_n_in || data_request_flag_out) ? 16'h0 :
			low_cnt_reg + 16'h1;

	sequence s_vol_off;
		wr_in.vol_we && wr_in.data == VOL_ANALOG_OFF;
	endsequence
	sequence s_pll_off;
		wr_in.clkmul_we && wr_in.data == CLKMUL_RESET;
	endsequence
	sequence s_soft_reset;
		wr_in.mode_we && wr_in.data[MODE_SOFT_RESET];
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0)
		!reset_n_in |=> !data_request_flag_out && crystal_out_ground_out
		&& !pll_enable_out && !analog_drivers_on_out)
		else $error("reset defaults missing");
	a_serial_gate: assert property (disable iff (1'b0)
		1'b1 |=> control_serial_out ==
		$past(serial_data_in && !control_select_low_in)
		&& control_serial_oe_n_out == $past(control_select_low_in))
		else $error("serial output not gated by select");
	a_boot_hold: assert property (
		$rose(data_request_flag_out) |-> low_cnt_reg >= BOOT_CYCLES)
		else $error("ready rose too early");
	a_soft_drop: assert property (
		s_soft_reset |-> ##[1:2] !data_request_flag_out)
		else $error("soft reset kept ready high");
	a_vol_off: assert property (
		s_vol_off |-> ##[1:3] !analog_drivers_on_out)
		else $error("analog drivers stayed on");
	a_pll_off: assert property (
		s_pll_off |-> ##[1:3] !pll_enable_out)
		else $error("pll stayed on");
	a_pos_none: assert property (
		!pos_exact_in |-> ##[1:2] exact_position_ms_out == POSITION_NONE)
		else $error("position not minus one");
	a_hdr_clear: assert property (
		!stream_valid_in |-> ##[1:2] stream_header_lo_out == HEADER_NONE
		&& stream_header_hi_out == HEADER_NONE)
		else $error("headers not cleared");
	a_cancel_done: assert property (
		cancel_done_in && mode_register_out[MODE_CANCEL]
		|-> ##[1:3] !mode_register_out[MODE_CANCEL])
		else $error("cancel bit not cleared");
	a_clk_halve: assert property (
		mode_register_out[MODE_HALVE] && $past(mode_register_out[MODE_HALVE])
		&& core_clk_en_out |=> !core_clk_en_out)
		else $error("input clock not halved");
endmodule // drpc_chk

bind drpc_top drpc_chk #(.BOOT_CYCLES(BOOT_CYCLES)) drpc_chk_i (.clk_in,
	.reset_n_in, .wr_in, .stream_valid_in, .cancel_done_in, .pos_exact_in,
	.control_select_low_in, .serial_data_in, .control_serial_out,
	.control_serial_oe_n_out, .mode_register_out, .stream_header_lo_out,
	.stream_header_hi_out, .exact_position_ms_out, .data_request_flag_out,
	.core_clk_en_out, .pll_enable_out, .analog_drivers_on_out,
	.crystal_out_ground_out);

/* File: bench/drpc_host.sv */
// Host controller model: turns register requests into one-cycle strobes.
// Assumes the bench calls put() from its main process only.
`timescale 1ns/100ps
module drpc_host
	import drpc_pkg::*;
(
	// Clock and ready flag
	input  wire logic          clk_in,
	input  wire logic          data_request_flag_in,
	// Write strobes toward the block
	output drpc_pkg::drpc_wr_t wr_out
);
	initial wr_out = '0;

	// Strobe bit order: mode, tone, clock, volume, rate, speed
	task automatic put(input int k, input logic [15:0] d);
		int n;
		n = 0;
		// wait for ready, halve bit excepted
		while (data_request_flag_in !== 1'b1 && !(k == 0 && d == 16'h8000) && n < 999)
		begin
			@(posedge clk_in);
			n++;
		end
		@(posedge clk_in);
		wr_out <= drpc_wr_t'({6'h20 >> k, d});
		@(posedge clk_in);
		wr_out <= '0;
	endtask
endmodule // drpc_host

/* File: bench/testbench.sv */
// Self-checking bench for the reset and playback control block.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/100ps
module testbench;
	import drpc_pkg::*;
	// Longer than the 2 us soft reset hold-off, so ready is still low then
	localparam int BOOT = 250;
	logic clk_in, reset_n_in, stream_valid_in, cancel_done_in, pos_exact_in;
	logic jump_blocked_in, control_select_low_in, serial_data_in;
	drpc_wr_t wr_in;
	drpc_hdr_t hdr_in;
	logic [31:0] pos_ms_in, exact_position_ms_out;
	logic [15:0] mode_register_out, tone_register_out, volume_register_out;
	logic [15:0] clock_multiplier_register_out, audio_rate_register_out;
	logic [15:0] speed_factor_out, stream_header_lo_out, stream_header_hi_out;
	logic control_serial_out, control_serial_oe_n_out, jump_blocked_bit_out;
	logic data_request_flag_out, core_clk_en_out, pll_enable_out;
	logic analog_drivers_on_out, crystal_out_ground_out, core_idle_out;
	logic low_rate_out;
	logic [2:0] pll_mult_out;
	logic [31:0] obs [17];
	logic [31:0] exp_q [$];
	int sel_q [$];
	int errors = 0;
	int n_tests = 0;
	int mc;
	event go;
	string nm [17] = '{"mode", "tone", "clk", "vol", "rate", "speed", "lo",
		"hi", "pos", "data_request_flag", "analog", "pll", "mult", "low", "xtal", "jump",
		"idle"};

	drpc_top #(.BOOT_CYCLES(BOOT)) drpc_top_i (.*);
	drpc_host drpc_host_i (.clk_in(clk_in), .data_request_flag_in(data_request_flag_out),
		.wr_out(wr_in));

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Observed results, indexed by the codes used in e()
	always_comb obs = '{32'(mode_register_out), 32'(tone_register_out),
		32'(clock_multiplier_register_out), 32'(volume_register_out),
		32'(audio_rate_register_out), 32'(speed_factor_out),
		32'(stream_header_lo_out), 32'(stream_header_hi_out),
		exact_position_ms_out, 32'(data_request_flag_out),
		32'(analog_drivers_on_out), 32'(pll_enable_out), 32'(pll_mult_out),
		32'(low_rate_out), 32'(crystal_out_ground_out),
		32'(jump_blocked_bit_out), 32'(core_idle_out)};

	// Random serial traffic keeps the output gate busy
	always @(posedge clk_in)
		{control_select_low_in, serial_data_in} <= 2'($urandom);

	task automatic check(input string s, input logic [31:0] x, g);
		n_tests++;
		if (g !== x)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", s, x, g);
		end
	endtask

	task automatic e(input int c, input logic [31:0] v);
		sel_q.push_back(c);
		exp_q.push_back(v);
		-> go;
	endtask

	// Monitor: 1 ns after the edge lets register updates land
	initial forever
	begin
		@(go);
		#1;
		while (sel_q.size() > 0)
		begin
			mc = sel_q.pop_front();
			check(nm[mc], exp_q.pop_front(), obs[mc]);
		end
	end

	task automatic we(input int k, input logic [15:0] d);
		drpc_host_i.put(k, d);
		repeat (2) @(posedge clk_in);
		e(k, 32'(k == 0 ? d & 16'hFFFB : d));
	endtask

	task automatic boot(input int n0);
		int n;
		n = n0;
		while (data_request_flag_out !== 1'b1 && n < 4 * BOOT)
		begin
			@(posedge clk_in);
			n++;
		end
		check("boot", 1, 32'(n >= BOOT && n < 4 * BOOT));
	endtask

	task automatic rst();
		reset_n_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		e(14, 1);
		e(10, 0);
		e(9, 0);
		e(5, 1);
		e(2, 0);
		reset_n_in <= 1'b1;
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog: whole sequence needs well under 2000 cycles
	initial
	begin
		#50000;
		errors++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(32'hD481));
		{reset_n_in, stream_valid_in, cancel_done_in, pos_exact_in} = '0;
		{jump_blocked_in, control_select_low_in, serial_data_in} = 3'h6;
		hdr_in = '0;
		pos_ms_in = '0;
		rst();
		boot(0);
		we(0, 16'h0000);
		we(1, 16'($urandom));
		we(2, CLKMUL_TYPICAL);
		e(12, 4);
		we(3, 16'h0000);
		e(10, 1);
		stream_valid_in <= 1'b1;
		hdr_in <= '{1'b1, 16'($urandom), 16'($urandom)};
		pos_exact_in <= 1'b1;
		pos_ms_in <= $urandom;
		jump_blocked_in <= 1'b0;
		we(5, 16'h0004);
		e(6, 32'(hdr_in.lo));
		e(8, pos_ms_in);
		e(15, 0);
		we(0, 16'h0008);
		cancel_done_in <= 1'b1;
		@(posedge clk_in);
		cancel_done_in <= 1'b0;
		{stream_valid_in, pos_exact_in} <= 2'h0;
		repeat (3) @(posedge clk_in);
		e(0, 0);
		e(7, 0);
		e(8, POSITION_NONE);
		e(16, 1);
		// no fill bytes are sent; clock cycles stand in for them while cancel pends
		// poll every 32 cycles, give up after 2048
		mc = 0;
		while (mode_register_out[MODE_CANCEL] !== 1'b0 && mc < 2048)
		begin
			repeat (32) @(posedge clk_in);
			mc += 32;
		end
		check("cancel", 1, 32'(mc < 2048));
		drpc_host_i.put(0, 16'h0004);
		e(9, 0);
		// hold off 2 us before looking at ready again
		repeat (SOFT_RESET_CYCLES) @(posedge clk_in);
		boot(SOFT_RESET_CYCLES);
		e(5, 4);
		we(2, 16'h0000);
		e(11, 0);
		we(2, 16'hE000);
		e(12, 6);
		we(3, VOL_ANALOG_OFF);
		e(10, 0);
		we(4, 16'h0010);
		e(13, 1);
		we(4, 16'h0100);
		e(13, 0);
		rst();
		drpc_host_i.put(0, 16'h8000);
		boot(0);
		mc = 0;
		repeat (20) @(negedge clk_in) mc += int'(core_clk_en_out);
		check("halve", 10, mc);
		tally_and_finish();
	end
endmodule // testbench

/* File: hw/drpc_pkg.sv */
// Shared constants and carrier types for the decoder reset and playback
// control block. Assumes a single 100 MHz core clock.
package drpc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned BOOT_INCLK_CYCLES  = 22000;
	localparam int unsigned SOFT_RESET_MIN_NS  = 2000;
	localparam int unsigned SOFT_RESET_CYCLES  =
		(SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Register values and field positions
	// ------------------------------------------------------------
	localparam logic [15:0] CLKMUL_RESET    = 16'h0000;
	localparam logic [15:0] CLKMUL_TYPICAL  = 16'h9800;
	localparam int unsigned CLKMUL_MSB      = 15;
	localparam int unsigned CLKMUL_LSB      = 13;
	localparam logic [2:0]  CLKMUL_MAX_CODE = 3'h7;
	localparam logic [15:0] VOL_RESET       = 16'h0000;
	localparam logic [15:0] VOL_ANALOG_OFF  = 16'hFFFF;
	localparam logic [15:0] RATE_RESET      = 16'h0000;
	localparam logic [15:0] RATE_LOW_LIMIT  = 16'h0100;
	localparam logic [15:0] HEADER_NONE     = 16'h0000;
	localparam logic [15:0] SPEED_NORMAL    = 16'h0001;
	localparam logic [31:0] POSITION_NONE   = 32'hFFFFFFFF;
	localparam int unsigned MODE_SOFT_RESET = 2;
	localparam int unsigned MODE_CANCEL     = 3;
	localparam int unsigned MODE_HALVE      = 15;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		DRPC_BOOT,
		DRPC_IDLE,
		DRPC_PLAY,
		DRPC_CANCEL
	} drpc_state_t;

	// Register write strobe bundle from the control port
	typedef struct packed
	{
		logic        mode_we;
		logic        tone_we;
		logic        clkmul_we;
		logic        vol_we;
		logic        rate_we;
		logic        speed_we;
		logic [15:0] data;
	} drpc_wr_t;

	// Header words reported by the decoder core
	typedef struct packed
	{
		logic        valid;
		logic [15:0] hi;
		logic [15:0] lo;
	} drpc_hdr_t;

endpackage : drpc_pkg

/* File: hw/drpc_top.sv */
// Reset, power-down and playback sequencing of the audio decoder.
// Assumes the control port decodes writes into one-cycle strobes and
// that the decoder core reports header, position and cancel completion.
`timescale 1ns/100ps

// Summary of operation
// RULE1: Reset low returns all control registers and state to initial values.
// RULE2: Reset is full power-down: clocks stop, crystal output held grounded.
// RULE3: Outputs default in reset; serial out still gated by select.
// RULE4: Data request stays low about 22000 input clocks after reset.
// RULE5: Host programs mode, tone, clock and volume before sending data.
// RULE6: Host sets halve bit early for 24..26 MHz clocks.
// RULE7: Clock multiplier supports 1.0x to 5.0x, resets to 1.0x. Code clamps the PLL code at 6, not the maximum code 7.
// RULE8: Host writes 0x9800 to clock register three for 3.5x.
// RULE9: Soft reset bit holds data request low about 22000 cycles.
// RULE10: Writing zero to clock multiplier selects 1.0x, PLL off.
// RULE11: Low non-zero audio rate lowers rate; core idles between interrupts.
// RULE12: Writing 0xffff to volume turns analog drivers off.
// RULE13: No decodable data clears both header registers.
// RULE14: Without input, device idles at low power watching stream input.
// RULE15: Host sends 2052 fill bytes then sets cancel at file end.
// RULE16: Host sends fill bytes, polls cancel; soft reset after 2048.
// RULE17: Completed cancel clears cancel bit and zeroes both headers.
// RULE18: Host aborts by setting cancel, polling every 32 bytes.
// RULE19: After abort clears, host sends 2052 fill bytes.
// RULE20: Speed factor write sets fast play; kept across song changes.
// RULE21: Jump blocked flag forbids host random jumps while set.
// RULE22: Exact position reads -1 when file has no exact timing.
// RULE23: Halve bit divides master clock by two at the input.
// RULE24: Host waits for data request before other transfers.
module drpc_top
	import drpc_pkg::*;
#(
	parameter int unsigned BOOT_CYCLES = BOOT_INCLK_CYCLES
)
(
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 reset_n_in,
	// Register writes and core reports
	input  wire drpc_pkg::drpc_wr_t   wr_in,
	input  wire drpc_pkg::drpc_hdr_t  hdr_in,
	input  wire logic                 stream_valid_in,
	input  wire logic                 cancel_done_in,
	input  wire logic                 jump_blocked_in,
	input  wire logic                 pos_exact_in,
	input  wire logic [31:0]          pos_ms_in,
	// Serial control output gating
	input  wire logic                 control_select_low_in,
	input  wire logic                 serial_data_in,
	output logic                      control_serial_out,
	output logic                      control_serial_oe_n_out,
	// Register read-back
	output logic [15:0]               mode_register_out,
	output logic [15:0]               tone_register_out,
	output logic [15:0]               clock_multiplier_register_out,
	output logic [15:0]               volume_register_out,
	output logic [15:0]               audio_rate_register_out,
	output logic [15:0]               speed_factor_out,
	output logic [15:0]               stream_header_lo_out,
	output logic [15:0]               stream_header_hi_out,
	output logic                      jump_blocked_bit_out,
	output logic [31:0]               exact_position_ms_out,
	// Power and clock control
	output logic                      data_request_flag_out,
	output logic                      core_clk_en_out,
	output logic                      pll_enable_out,
	output logic [2:0]                pll_mult_out,
	output logic                      analog_drivers_on_out,
	output logic                      crystal_out_ground_out,
	output logic                      core_idle_out,
	output logic                      low_rate_out
);
	import drpc_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	drpc_state_t  state_reg, state_next;
	logic [15:0]  mode_reg, tone_reg, clkmul_reg, vol_reg;
	logic [15:0]  rate_reg, speed_reg, hdr_lo_reg, hdr_hi_reg;
	logic [14:0]  boot_cnt_reg;
	logic         half_tick_reg;
	logic         in_tick;
	logic         boot_done;
	logic         soft_reset_req;
	logic         cancel_set;
	logic         cancel_clr;
	logic [15:0]  mode_next;
	logic [2:0]   mult_code;
	logic         clear_headers;

	// ------------------------------------------------------------
	// Decoding of requests
	// ------------------------------------------------------------
	// RULE23: halve at input
	assign in_tick = ~mode_reg[MODE_HALVE] | half_tick_reg;
	// RULE4: boot hold length
	assign boot_done      = (boot_cnt_reg == 15'(BOOT_CYCLES - 1)) && in_tick;
	// RULE9: soft reset request
	assign soft_reset_req = wr_in.mode_we && wr_in.data[MODE_SOFT_RESET];
	assign cancel_set     = wr_in.mode_we && wr_in.data[MODE_CANCEL];
	// RULE17: core clears cancel
	assign cancel_clr     = (state_reg == DRPC_CANCEL) && cancel_done_in;
	// Set wins over the core's clear in the same cycle
	assign mode_next = wr_in.mode_we
		? {wr_in.data[15:4], cancel_set, 1'b0, wr_in.data[1:0]}
		: {mode_reg[15:4], mode_reg[MODE_CANCEL] & ~cancel_clr,
		   mode_reg[2:0]};
	// RULE7: clamp the multiplier code to 6, below CLKMUL_MAX_CODE
	assign mult_code = (clkmul_reg[CLKMUL_MSB:CLKMUL_LSB] > 3'h6)
		? 3'h6 : clkmul_reg[CLKMUL_MSB:CLKMUL_LSB];
	// RULE13: no decodable data
	assign clear_headers = cancel_clr || !stream_valid_in || !hdr_in.valid;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			DRPC_BOOT:
				if (boot_done)
					state_next = DRPC_IDLE;
			// RULE14: idle watches input
			DRPC_IDLE:
				if (stream_valid_in)
					state_next = DRPC_PLAY;
			DRPC_PLAY:
				if (cancel_set)
					state_next = DRPC_CANCEL;
				else if (!stream_valid_in)
					state_next = DRPC_IDLE;
			DRPC_CANCEL:
				if (cancel_done_in)
					state_next = DRPC_IDLE;
		endcase
		if (soft_reset_req)
			state_next = DRPC_BOOT;
	end

	// RULE1: synchronous restart of state
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			state_reg <= DRPC_BOOT;
		else
			state_reg <= state_next;
	end

	// Input clock divider and boot counter; only counts core input ticks
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in || soft_reset_req)
		begin
			boot_cnt_reg  <= 15'h0000;
			half_tick_reg <= 1'b0;
		end
		else
		begin
			half_tick_reg <= ~half_tick_reg;
			if (state_reg == DRPC_BOOT && in_tick && !boot_done)
				boot_cnt_reg <= boot_cnt_reg + 15'h0001;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// RULE1: registers to initial values
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			mode_reg   <= 16'h0000;
			tone_reg   <= 16'h0000;
			clkmul_reg <= CLKMUL_RESET;
			vol_reg    <= VOL_RESET;
			rate_reg   <= RATE_RESET;
			speed_reg  <= SPEED_NORMAL;
		end
		else
		begin
			mode_reg <= mode_next;
			if (wr_in.tone_we)
				tone_reg <= wr_in.data;
			// RULE10: zero turns PLL off
			if (wr_in.clkmul_we)
				clkmul_reg <= wr_in.data;
			// RULE12: volume write
			if (wr_in.vol_we)
				vol_reg <= wr_in.data;
			if (wr_in.rate_we)
				rate_reg <= wr_in.data;
			// RULE20: survives song change
			if (wr_in.speed_we)
				speed_reg <= wr_in.data;
		end
	end

	// RULE17: headers zero on cancel end
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in || soft_reset_req || clear_headers)
		begin
			hdr_lo_reg <= HEADER_NONE;
			hdr_hi_reg <= HEADER_NONE;
		end
		else
		begin
			hdr_lo_reg <= hdr_in.lo;
			hdr_hi_reg <= hdr_in.hi;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			// RULE2: power-down defaults
			// RULE3: outputs at defaults
			data_request_flag_out         <= 1'b0;
			core_clk_en_out               <= 1'b0;
			pll_enable_out                <= 1'b0;
			pll_mult_out                  <= 3'h0;
			analog_drivers_on_out         <= 1'b0;
			crystal_out_ground_out        <= 1'b1;
			core_idle_out                 <= 1'b0;
			low_rate_out                  <= 1'b0;
			mode_register_out             <= 16'h0000;
			tone_register_out             <= 16'h0000;
			clock_multiplier_register_out <= CLKMUL_RESET;
			volume_register_out           <= VOL_RESET;
			audio_rate_register_out       <= RATE_RESET;
			speed_factor_out              <= SPEED_NORMAL;
			stream_header_lo_out          <= HEADER_NONE;
			stream_header_hi_out          <= HEADER_NONE;
			jump_blocked_bit_out          <= 1'b1;
			exact_position_ms_out         <= POSITION_NONE;
		end
		else
		begin
			// RULE4: flag low during boot
			data_request_flag_out  <= (state_next != DRPC_BOOT);
			core_clk_en_out        <= in_tick;
			// RULE10: PLL off at 1.0x
			pll_enable_out         <= (mult_code != 3'h0);
			pll_mult_out           <= mult_code;
			// RULE12: analog power-down
			analog_drivers_on_out  <= (vol_reg != VOL_ANALOG_OFF);
			crystal_out_ground_out <= 1'b0;
			// RULE11: slow rate lets core idle
			low_rate_out  <= (rate_reg != 16'h0000) &&
				(rate_reg < RATE_LOW_LIMIT);
			core_idle_out <= (state_reg == DRPC_IDLE) ||
				((rate_reg != 16'h0000) && (rate_reg < RATE_LOW_LIMIT));
			mode_register_out             <= mode_reg;
			tone_register_out             <= tone_reg;
			clock_multiplier_register_out <= clkmul_reg;
			volume_register_out           <= vol_reg;
			audio_rate_register_out       <= rate_reg;
			speed_factor_out              <= speed_reg;
			stream_header_lo_out          <= hdr_lo_reg;
			stream_header_hi_out          <= hdr_hi_reg;
			// RULE21: jump blocked report
			jump_blocked_bit_out <= jump_blocked_in ||
				(state_reg != DRPC_PLAY);
			// RULE22: minus one without timing
			exact_position_ms_out <= pos_exact_in ? pos_ms_in
				: POSITION_NONE;
		end
	end

	// RULE3: serial out gated by select even in reset
	always_ff @(posedge clk_in)
	begin
		control_serial_out      <= serial_data_in & ~control_select_low_in;
		control_serial_oe_n_out <= control_select_low_in;
	end

endmodule // drpc_top
